// >>> hw/vgaac_pkg.sv
// Purpose: Shared constants and carriers for the attribute controller
// Assumes: Host I/O port numbers are 16-bit
// Notes:   Register indices follow the attribute index space
package vgaac_pkg;
  // ----------------------------------------
  // Port addresses and indices
  // ----------------------------------------
  localparam logic [15:0] VGAAC_PORT_WR    = 16'h03C0;
  localparam logic [15:0] VGAAC_PORT_RD    = 16'h03C1;
  localparam logic [4:0]  VGAAC_IDX_MODE   = 5'h10;
  localparam logic [4:0]  VGAAC_IDX_BORDER = 5'h11;
  localparam logic [4:0]  VGAAC_IDX_PLANE  = 5'h12;
  localparam logic [4:0]  VGAAC_IDX_PAN    = 5'h13;
  localparam logic [4:0]  VGAAC_IDX_CSEL   = 5'h14;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int VGAAC_IX_VIDEO_EN   = 5;
  localparam int VGAAC_MD_CSEL_SRC   = 7;
  localparam int VGAAC_MD_DBL_CLK    = 6;
  localparam int VGAAC_MD_PAN_COMPAT = 5;
  localparam int VGAAC_MD_BLINK_EN   = 3;
  localparam int VGAAC_MD_LINE_GFX   = 2;
  localparam int VGAAC_MD_GFX        = 0;
  // ----------------------------------------
  // Reset values and constants
  // ----------------------------------------
  localparam logic [7:0] VGAAC_RST_VAL    = 8'h00;
  localparam logic [7:0] VGAAC_LGFX_LO    = 8'hC0;
  localparam logic [7:0] VGAAC_LGFX_HI    = 8'hDF;
  localparam logic [4:0] VGAAC_BLINK_DIV  = 5'h1F;
  localparam logic [3:0] VGAAC_PAN_ZERO   = 4'h0;

  // Host I/O request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } vgaac_io_t;

  // Pixel-side input
  typedef struct packed {
    logic       active;   // Active video
    logic       blank;    // Blanking
    logic       vsync;
    logic       line_cmp; // Line compare match
    logic       text_9th; // Ninth dot column of a 9-dot cell
    logic       dot8;     // Eighth dot of this cell
    logic       fg;       // Glyph dot set
    logic [7:0] char_code;
    logic [7:0] attr;
    logic [3:0] planes;   // Plane data pixel
    logic       direct;   // 8/16/24-bit pixel mode
    logic       cga_mode;
  } vgaac_pix_t;
endpackage

// >>> hw/vgaac_top.sv
// What this block does
// - Port writes alternate index then data
// - Write at 3C0, read data at 3C1
// - Toggle state readable as status bit
// - Index bits readable while toggle shows index
// - Index bit 5 clear shows border only
// - Sixteen 6-bit palette pointers selected by pixel
// - Mode bit 7 picks lookup bits 5:4
// - Mode bit 6 halves pixel rate, bypasses palette in graphics mode
// - Line compare zeroes pan until vsync
// - Blink toggles at vertical rate over 32
// - Line graphics copies dot 8 for C0h-DFh
// - Mode bit 0 selects text or graphics
// - Border uses 4 bits CGA, 6 EGA
// - Border colour between blanking and active video
// - Plane register: diag select and plane enables
// - Cleared plane enable masks that plane, except in direct pixel mode
// - Diagnostic select routes pixel bits to status
// - Colour select upper bits feed lookup 7:6
//
// Purpose: Attribute controller turning plane pixels into lookup addresses
// Assumes: One clock, synchronous host I/O strobes of one cycle
// Notes:   Status port reads arrive as a strobe from the general status decode
`timescale 1ns/1ps
module vgaac_top (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire vgaac_pkg::vgaac_io_t  io,
  input  wire logic             status_rd,
  input  wire vgaac_pkg::vgaac_pix_t pix,
  output logic [7:0]            rdata,
  output logic                  toggle_state_status,
  output logic [4:0]            index_readback_field,
  output logic [7:0]            lut_addr,
  output logic [1:0]            diag_status,
  output logic [3:0]            fine_pan_shift,
  output logic                  pix_adv
);
  import vgaac_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic       data_next;
    logic [7:0] attribute_index_select;
    logic [15:0][5:0] palette_pointer_set;
    logic [7:0] attribute_mode_control;
    logic [7:0] border_colour_select;
    logic [7:0] plane_enable_and_diag;
    logic [3:0] fine_pan_reg;
    logic [3:0] colour_select_upper;
    logic       pan_hold;
    logic [4:0] blink_cnt;
    logic       blink_ph;
    logic       vs_d;
    logic       phase;
    logic [7:0] rdata;
    logic [7:0] lut;
    logic [1:0] diag;
    logic [3:0] pan;
    logic       adv;
    logic [4:0] idx_rb;
  } vgaac_state_t;

  vgaac_state_t s_r;
  vgaac_state_t s_nxt;

  logic [7:0] rd_mux;
  logic [3:0] pix_m;
  logic [7:0] pbus;
  logic [5:0] pal;

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  // Reserved bits read as zero
  always_comb begin
    rd_mux = 8'h00;
    if (s_r.attribute_index_select[4] == 1'b0) begin
      rd_mux = {2'b00, s_r.palette_pointer_set[s_r.attribute_index_select[3:0]]};
    end else begin
      case (s_r.attribute_index_select[4:0])
        VGAAC_IDX_MODE:   rd_mux = s_r.attribute_mode_control & 8'hEF;
        VGAAC_IDX_BORDER: rd_mux = {2'b00, s_r.border_colour_select[5:0]};
        VGAAC_IDX_PLANE:  rd_mux = {2'b00, s_r.plane_enable_and_diag[5:0]};
        VGAAC_IDX_PAN:    rd_mux = {4'h0, s_r.fine_pan_reg};
        VGAAC_IDX_CSEL:   rd_mux = {4'h0, s_r.colour_select_upper};
        default:          rd_mux = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Pixel path
  // ----------------------------------------
  // Plane mask, then palette or bypass, then colour select
  always_comb begin
    pix_m = pix.planes & s_r.plane_enable_and_diag[3:0];
    pal   = s_r.palette_pointer_set[pix_m];
    if (s_r.attribute_mode_control[VGAAC_MD_CSEL_SRC] && !pix.direct) begin
      pal[5:4] = s_r.colour_select_upper[1:0];
    end
    pbus = {s_r.colour_select_upper[3:2], pal};
    if (s_r.attribute_mode_control[VGAAC_MD_DBL_CLK]) begin
      pbus = {s_r.colour_select_upper[3:0], pix_m};
    end
    if (pix.direct) begin
      pbus = {4'h0, pix.planes};
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [3:0] txt;
    logic       dot;
    logic       on;
    s_nxt = s_r;
    txt   = 4'h0;
    dot   = 1'b0;
    on    = 1'b0;
    s_nxt.rdata = s_r.rdata;
    // Host writes to the shared port
    if (io.wr && io.addr == VGAAC_PORT_WR) begin
      s_nxt.data_next = ~s_r.data_next;
      if (!s_r.data_next) begin
        s_nxt.attribute_index_select = {2'b00, io.wdata[5:0]};
      end else if (s_r.attribute_index_select[4] == 1'b0) begin
        s_nxt.palette_pointer_set[s_r.attribute_index_select[3:0]] = io.wdata[5:0];
      end else begin
        case (s_r.attribute_index_select[4:0])
          VGAAC_IDX_MODE:   s_nxt.attribute_mode_control = io.wdata & 8'hEF;
          VGAAC_IDX_BORDER: s_nxt.border_colour_select = {2'b00, io.wdata[5:0]};
          VGAAC_IDX_PLANE:  s_nxt.plane_enable_and_diag = {2'b00, io.wdata[5:0]};
          VGAAC_IDX_PAN:    s_nxt.fine_pan_reg = io.wdata[3:0];
          VGAAC_IDX_CSEL:   s_nxt.colour_select_upper = io.wdata[3:0];
          default:          s_nxt.fine_pan_reg = s_r.fine_pan_reg;
        endcase
      end
    end
    // Status read forces next write to be an index; a write in same cycle still lands but its toggle flip is lost
    if (status_rd) begin
      s_nxt.data_next = 1'b0;
    end
    // Readback registered so the output comes straight from a flop
    s_nxt.idx_rb = s_nxt.data_next ? 5'h00 : s_nxt.attribute_index_select[4:0];
    if (io.rd && io.addr == VGAAC_PORT_RD) begin
      s_nxt.rdata = rd_mux;
    end
    // Blink divider counts vertical syncs
    s_nxt.vs_d = pix.vsync;
    if (pix.vsync && !s_r.vs_d) begin
      s_nxt.blink_cnt = s_r.blink_cnt + 5'h01;
      if (s_r.blink_cnt == VGAAC_BLINK_DIV) begin
        s_nxt.blink_ph = ~s_r.blink_ph;
      end
      s_nxt.pan_hold = 1'b0;
    end else if (pix.line_cmp && s_r.attribute_mode_control[VGAAC_MD_PAN_COMPAT]) begin
      s_nxt.pan_hold = 1'b1;
    end
    s_nxt.pan = s_nxt.pan_hold ? VGAAC_PAN_ZERO : s_r.fine_pan_reg;
    // Pixel advance halves in double-clock mode
    s_nxt.phase = s_r.attribute_mode_control[VGAAC_MD_DBL_CLK] ? ~s_r.phase : 1'b1;
    s_nxt.adv   = s_nxt.phase;
    // Text attribute decode
    dot = pix.fg;
    if (pix.text_9th) begin
      dot = (s_r.attribute_mode_control[VGAAC_MD_LINE_GFX] && pix.char_code >= VGAAC_LGFX_LO &&
             pix.char_code <= VGAAC_LGFX_HI) ? pix.dot8 : 1'b0;
    end
    on = dot;
    if (s_r.attribute_mode_control[VGAAC_MD_BLINK_EN] && pix.attr[7] && s_r.blink_ph) begin
      on = 1'b0;
    end
    txt = on ? pix.attr[3:0] : (s_r.attribute_mode_control[VGAAC_MD_BLINK_EN] ?
                                {1'b0, pix.attr[6:4]} : pix.attr[7:4]);
    // Lookup address generation
    // Blanking outranks border and video so the retrace stays dark
    if (pix.blank) begin
      s_nxt.lut = 8'h00;
    end else if (!s_r.attribute_index_select[VGAAC_IX_VIDEO_EN] || !pix.active) begin
      s_nxt.lut = pix.cga_mode ? {4'h0, s_r.border_colour_select[3:0]} :
                                 {2'b00, s_r.border_colour_select[5:0]};
    end else if (!s_r.attribute_mode_control[VGAAC_MD_GFX] && !pix.direct) begin
      s_nxt.lut = {s_r.colour_select_upper[3:2],
                   s_r.attribute_mode_control[VGAAC_MD_CSEL_SRC] ? s_r.colour_select_upper[1:0] :
                   s_r.palette_pointer_set[txt & s_r.plane_enable_and_diag[3:0]][5:4],
                   s_r.palette_pointer_set[txt & s_r.plane_enable_and_diag[3:0]][3:0]};
    end else begin
      s_nxt.lut = pbus;
    end
    // Diagnostic routing
    case (s_r.plane_enable_and_diag[5:4])
      2'b00:   s_nxt.diag = {pbus[2], pbus[0]};
      2'b01:   s_nxt.diag = {pbus[5], pbus[4]};
      2'b10:   s_nxt.diag = {pbus[3], pbus[1]};
      default: s_nxt.diag = {pbus[7], pbus[6]};
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops
  assign rdata                = s_r.rdata;
  assign toggle_state_status  = s_r.data_next;
  assign index_readback_field = s_r.idx_rb;
  assign lut_addr             = s_r.lut;
  assign diag_status          = s_r.diag;
  assign fine_pan_shift       = s_r.pan;
  assign pix_adv              = s_r.adv;
endmodule

// >>> tb/vgaac_assertions.sv
// Purpose: Port-level checks of the attribute controller
// Assumes: Single clock, synchronous active-high reset
// Notes:   Shadows index and mode so mode-gated checks know the setting
`timescale 1ns/1ps
module vgaac_assertions (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire vgaac_pkg::vgaac_io_t  io,
  input wire logic                 status_rd,
  input wire vgaac_pkg::vgaac_pix_t pix,
  input wire logic [7:0]           rdata,
  input wire logic                 toggle_state_status,
  input wire logic [4:0]           index_readback_field,
  input wire logic [7:0]           lut_addr,
  input wire logic [1:0]           diag_status,
  input wire logic [3:0]           fine_pan_shift,
  input wire logic                 pix_adv
);
  import vgaac_pkg::*;
  logic       hit;
  logic [4:0] idx_r;
  logic [7:0] mode_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Write at the attribute port that the toggle honours
  assign hit = io.wr && io.addr == VGAAC_PORT_WR && !status_rd;
  // Shadow of index and mode; status reads win over writes
  always_ff @(posedge clk) begin
    if (rst) begin
      idx_r  <= 5'h00;
      mode_r <= 8'h00;
    end else if (hit && !toggle_state_status) begin
      idx_r <= io.wdata[4:0];
    end else if (hit && idx_r == VGAAC_IDX_MODE) begin
      mode_r <= io.wdata;
    end
  end
  // ----------------------------------------
  // Host side
  // ----------------------------------------
  chk_toggle_flips: assert property (hit |=> toggle_state_status != $past(toggle_state_status))
    else $error("toggle did not alternate");
  chk_status_clears: assert property (status_rd |=> !toggle_state_status)
    else $error("status read left toggle set");
  chk_index_readback: assert property (index_readback_field == (toggle_state_status ? 5'h00 : idx_r))
    else $error("index readback wrong");
  chk_port_ignored: assert property (io.wr && io.addr != VGAAC_PORT_WR && !status_rd |=> $stable(toggle_state_status))
    else $error("foreign port moved toggle");
  chk_rdata_holds: assert property (!(io.rd && io.addr == VGAAC_PORT_RD) |=> $stable(rdata))
    else $error("read data changed without read");
  // ----------------------------------------
  // Pixel side
  // ----------------------------------------
  chk_blank_zero: assert property (pix.blank |=> lut_addr == 8'h00)
    else $error("blanking not zero");
  chk_double_adv: assert property (mode_r[VGAAC_MD_DBL_CLK] && $past(mode_r[VGAAC_MD_DBL_CLK]) |=> pix_adv != $past(pix_adv))
    else $error("pixel advance not alternating");
  chk_pan_hold: assert property (mode_r[VGAAC_MD_PAN_COMPAT] && pix.line_cmp && !pix.vsync ##1 !pix.vsync [*2] |-> fine_pan_shift == VGAAC_PAN_ZERO)
    else $error("pan not forced to zero");
endmodule

// >>> tb/vgaac_host.sv
// Purpose: Host model issuing attribute port cycles
// Assumes: One-cycle strobes driven just after a rising edge
// Notes:   Released lines show the inverse so stale values never look valid
`timescale 1ns/1ps
module vgaac_host (
  input  wire logic            clk,
  input  wire logic [7:0]      rdata,
  output vgaac_pkg::vgaac_io_t io,
  output logic                 status_rd
);
  import vgaac_pkg::*;
  initial begin
    io = '0;
    status_rd = 1'b0;
  end
  // Write strobe; wreg pairs index then data, other callers send an index alone
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    io <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Read strobe, data taken a cycle later
  task automatic get(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    io <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: io.wdata};
    @(posedge clk);
    io <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: io.wdata};
    @(posedge clk);
    d = rdata;
  endtask
  // Status read pulse resets the toggle
  task automatic clr();
    @(posedge clk);
    status_rd <= 1'b1;
    @(posedge clk);
    status_rd <= 1'b0;
  endtask
endmodule

// >>> tb/vga_attribute_controller_test.sv
// Purpose: Self-checking bench for the attribute controller
// Assumes: 125 MHz clock, reset held 10 cycles
// Notes:   Reset and toggle checks first, then register rows, then pixel path cases by hand
`timescale 1ns/1ps
module vga_attribute_controller_test;
  import vgaac_pkg::*;
  logic clk = 1'b0, rst = 1'b1, status_rd, toggle_state_status, pix_adv;
  logic [7:0] rdata, lut_addr, v;
  logic [4:0] index_readback_field;
  logic [1:0] diag_status;
  logic [3:0] fine_pan_shift;
  vgaac_io_t  io;
  vgaac_pix_t pix = '0;
  int n_errors = 0, checks_done = 0;
  // Index, data, expected read; unmapped index reads zero
  logic [7:0] rows [7][3] = '{'{8'h03, 8'h2A, 8'h2A}, '{8'h11, 8'h3F, 8'h3F}, '{8'h12, 8'h0F, 8'h0F},
    '{8'h13, 8'h07, 8'h07}, '{8'h14, 8'h0C, 8'h0C}, '{8'h10, 8'h01, 8'h01}, '{8'h15, 8'h55, 8'h00}};
  always #4 clk = ~clk;
  vgaac_top vgaac_top_i (.clk(clk), .rst(rst), .io(io), .status_rd(status_rd), .pix(pix), .rdata(rdata),
    .toggle_state_status(toggle_state_status), .index_readback_field(index_readback_field),
    .lut_addr(lut_addr), .diag_status(diag_status), .fine_pan_shift(fine_pan_shift), .pix_adv(pix_adv));
  vgaac_host vgaac_host_i (.clk(clk), .rdata(rdata), .io(io), .status_rd(status_rd));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    vgaac_host_i.put(VGAAC_PORT_WR, i);
    vgaac_host_i.put(VGAAC_PORT_WR, d);
  endtask
  task automatic rreg(input logic [7:0] i, output logic [7:0] d);
    vgaac_host_i.put(VGAAC_PORT_WR, i);
    vgaac_host_i.get(VGAAC_PORT_RD, d);
    vgaac_host_i.clr();
  endtask
  // Pixel outputs lag inputs by a register stage
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rreg(8'h32, v);
    cmp(v, 8'h00);
    vgaac_host_i.put(VGAAC_PORT_WR, 8'h34);
    #1 cmp({7'h0, toggle_state_status}, 8'h01);
    cmp({3'h0, index_readback_field}, 8'h00);
    vgaac_host_i.clr();
    #1 cmp({3'h0, index_readback_field}, 8'h14);
    cmp({7'h0, toggle_state_status}, 8'h00);
    $display("reset and toggle test done");
    foreach (rows[k]) begin
      wreg(rows[k][0] | 8'h20, rows[k][1]);
      rreg(rows[k][0] | 8'h20, v);
      cmp(v, rows[k][2]);
    end
    $display("register rows done");
    @(posedge clk);
    pix.planes <= 4'h3;
    pix.active <= 1'b1;
    settle();
    cmp(lut_addr, 8'hEA);
    wreg(8'h30, 8'h81);
    settle();
    cmp(lut_addr, 8'hCA);
    wreg(8'h32, 8'h0E);
    settle();
    cmp(lut_addr, 8'hC0);
    vgaac_host_i.put(VGAAC_PORT_WR, 8'h00);
    vgaac_host_i.clr();
    settle();
    cmp(lut_addr, 8'h3F);
    pix.blank <= 1'b1;
    settle();
    cmp(lut_addr, 8'h00);
    wreg(8'h32, 8'h0F);
    pix.blank <= 1'b0;
    pix.active <= 1'b0;
    settle();
    cmp(lut_addr, 8'h3F);
    pix.cga_mode <= 1'b1;
    settle();
    cmp(lut_addr, 8'h0F);
    $display("pixel path test done");
    wreg(8'h30, 8'h21);
    pix.line_cmp <= 1'b1;
    @(posedge clk);
    pix.line_cmp <= 1'b0;
    settle();
    cmp({4'h0, fine_pan_shift}, 8'h00);
    pix.vsync <= 1'b1;
    settle();
    cmp({4'h0, fine_pan_shift}, 8'h07);
    wreg(8'h30, 8'h41);
    pix.active <= 1'b1;
    settle();
    cmp(lut_addr, 8'hC3);
    cmp({6'h0, diag_status}, 8'h01);
    v = {7'h0, pix_adv};
    @(posedge clk);
    #1 cmp({7'h0, pix_adv}, v ^ 8'h01);
    wreg(8'h32, 8'h3F);
    settle();
    cmp({6'h0, diag_status}, 8'h03);
    $display("pan and double clock test done");
    wreg(8'h2E, 8'h15);
    wreg(8'h30, 8'h04);
    pix.text_9th <= 1'b1;
    pix.dot8 <= 1'b1;
    pix.char_code <= 8'hC5;
    pix.attr <= 8'h1E;
    settle();
    cmp(lut_addr, 8'hD5);
    pix.char_code <= 8'h41;
    settle();
    cmp(lut_addr, 8'hC0);
    pix.char_code <= 8'hC5;
    pix.attr <= 8'h9E;
    wreg(8'h30, 8'h0C);
    // One vsync edge already seen; 30 more keep the phase
    repeat (30) begin
      pix.vsync <= 1'b0;
      @(posedge clk);
      pix.vsync <= 1'b1;
      @(posedge clk);
    end
    settle();
    cmp(lut_addr, 8'hD5);
    pix.vsync <= 1'b0;
    @(posedge clk);
    pix.vsync <= 1'b1;
    settle();
    cmp(lut_addr, 8'hC0);
    $display("text and blink test done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 cmp(lut_addr, 8'h00);
    cmp({7'h0, toggle_state_status}, 8'h00);
    vgaac_host_i.put(VGAAC_PORT_WR, 8'h31);
    #1 cmp({7'h0, toggle_state_status}, 8'h01);
    $display("mid-run reset test done");
    final_report();
  end
endmodule
bind vgaac_top vgaac_assertions vgaac_assertions_i (.clk(clk), .rst(rst), .io(io), .status_rd(status_rd),
  .pix(pix), .rdata(rdata), .toggle_state_status(toggle_state_status),
  .index_readback_field(index_readback_field), .lut_addr(lut_addr), .diag_status(diag_status),
  .fine_pan_shift(fine_pan_shift), .pix_adv(pix_adv));
